// ===== remote_node.sv
// Behavioural remote serial node: decodes TXD, drives RXD and CTS_N.
// Assumes bit_clks is sixteen times the block's divisor.
`timescale 1ns/1ps
`default_nettype none
module remote_node (
  // Clock
  input  wire logic        clk,
  // From the block, and frame settings from the bench
  input  wire logic        txd,
  input  wire logic        extra_on,
  input  wire logic [15:0] bit_clks,
  // To the block
  output var logic         rxd,
  output var logic         cts_n
);
  logic [7:0] got_data;
  logic       got_extra;
  logic       got_stop;
  int         frames;
  initial
  begin
    rxd = 1'h1;
    cts_n = 1'h0;
    frames = 0;
  end
  // Mid-bit sampling of each outgoing character
  always
  begin
    @(negedge txd);
    repeat (bit_clks / 2) @(posedge clk);
    if (txd === 1'h0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (bit_clks) @(posedge clk);
        got_data[i] = txd;
      end
      if (extra_on)
      begin
        repeat (bit_clks) @(posedge clk);
        got_extra = txd;
      end
      repeat (bit_clks) @(posedge clk);
      got_stop = txd;
      frames++;
    end
  end
  task automatic send_char(input logic [7:0] d, input logic xen, input logic x);
    logic [10:0] b;
    b = {1'h1, x, d, 1'h0};
    for (int i = 0; i < 11; i++)
    begin
      if (i != 9 || xen)
      begin
        rxd <= b[i];
        repeat (bit_clks) @(posedge clk);
      end
    end
  endtask
  task automatic set_cts(input logic v);
    @(posedge clk);
    cts_n <= v;
  endtask
endmodule // remote_node
`default_nettype wire

// ===== tb.sv
// Self-checking bench for uart_txrx against a remote node model.
// Assumes the checker binds itself from its own file.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {
    logic [7:0] data;
    logic [7:0] div;
    logic par_on, odd, md, ninth, xbit;
  } row_s;
  row_s        rows [6];
  logic        clk, rst, tx_on, rx_on, par_on, par_odd, two_stop, flow_on, md_on;
  logic        ninth, err_only, tx_wr, rx_rd, rxd, cts_n, txd, tx_empty;
  logic        rx_ninth, rx_ready, rx_perr, rx_irq, rx_nf, rx_ferr, rx_brk, tx_irq;
  logic [1:0]  scheme;
  logic [7:0]  div, tx_data, rx_data;
  logic [15:0] bit_clks;
  logic [7:0]  md_exp [3][2];
  int          bad_count, tests_run, nf, k;
  uart_txrx u_dut (.REF_CLK(clk), .RST(rst), .DIV_HIGH(8'h00), .DIV_LOW(div),
    .TX_ON(tx_on), .RX_ON(rx_on), .PARITY_ON(par_on), .PARITY_ODD(par_odd),
    .TWO_STOP(two_stop), .FLOW_CTRL_ON(flow_on), .MULTIDROP_ON(md_on),
    .MULTIDROP_MATCH_SCHEME(scheme), .TX_NINTH_BIT(ninth), .RX_ERR_IRQ_ONLY(err_only),
    .OWN_ADDRESS(8'h5A), .TX_WRITE(tx_wr), .TX_DATA(tx_data), .RX_READ(rx_rd),
    .RX_DATA(rx_data), .RX_NINTH_BIT(rx_ninth), .RX_NEW_FRAME(rx_nf), .TX_BUSY(),
    .TX_HOLDING_EMPTY(tx_empty), .RX_BYTE_READY(rx_ready), .RX_PARITY_ERR(rx_perr),
    .RX_FRAME_ERR(rx_ferr), .RX_BREAK(rx_brk), .RX_OVERRUN(), .TX_IRQ(tx_irq), .RX_IRQ(rx_irq),
    .TXD(txd), .RXD(rxd), .CTS_N(cts_n));
  remote_node u_peer (.clk(clk), .txd(txd), .extra_on(par_on | md_on),
    .bit_clks(bit_clks), .rxd(rxd), .cts_n(cts_n));
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("Checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic write_tx(input logic [7:0] d);
    @(posedge clk);
    tx_data <= d;
    tx_wr <= 1'h1;
    @(posedge clk);
    tx_wr <= 1'h0;
  endtask
  // Bounded wait for the node to decode a further character
  task automatic tx_frame(input logic [7:0] d);
    nf++;
    for (k = 0; u_peer.frames < nf && k < 9000; k++)
      @(posedge clk);
    #1;
    check("frames", 8'(nf), 8'(u_peer.frames));
    check("tx data", d, u_peer.got_data);
    check("tx stop", 1'h1, u_peer.got_stop);
  endtask
  task automatic pop_rx(input logic [7:0] d, input logic n9, input logic pe);
    #1;
    for (k = 0; rx_ready !== 1'h1 && k < 400; k++)
      @(posedge clk) #1;
    check("rx ready", 1'h1, rx_ready);
    check("rx data", d, rx_data);
    check("rx parity err", pe, rx_perr);
    if (md_on) check("rx ninth", n9, rx_ninth);
    @(posedge clk);
    rx_rd <= 1'h1;
    @(posedge clk);
    rx_rd <= 1'h0;
  endtask
  task automatic txd_low();
    for (k = 0; txd !== 1'h0 && k < 400; k++)
      @(posedge clk) #1;
    check("txd start", 1'h0, txd);
  endtask
  initial
  begin
    {tx_on, rx_on, par_on, par_odd, two_stop, flow_on, md_on} = 7'h61;
    {ninth, err_only, tx_wr, rx_rd, scheme, tx_data, div} = 22'h000001;
    {rst, bit_clks, bad_count, tests_run, nf} = {1'h1, 16'h0010, 96'h0};
    rows = '{'{8'hA5, 8'h01, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0},
             '{8'hA5, 8'h01, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0},
             '{8'hA5, 8'h01, 1'h1, 1'h1, 1'h0, 1'h0, 1'h1},
             '{8'h80, 8'h02, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1},
             '{8'h3C, 8'h01, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1},
             '{8'h01, 8'h01, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0}};
    md_exp = '{'{8'h33, 8'h5A}, '{8'h5A, 8'h22}, '{8'h22, 8'h00}};
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk) #1;
    check("txd idle", 1'h1, txd);
    check("tx empty", 1'h1, tx_empty);
    check("tx irq", 1'h1, tx_irq);
    foreach (rows[i])
    begin
      @(posedge clk);
      {div, par_on, par_odd, md_on, ninth} <= {rows[i].div, rows[i].par_on,
        rows[i].odd, rows[i].md, rows[i].ninth};
      bit_clks <= {4'h0, rows[i].div, 4'h0};
      write_tx(rows[i].data);
      tx_frame(rows[i].data);
      if (par_on | md_on) check("tx extra", rows[i].xbit, u_peer.got_extra);
      u_peer.send_char(rows[i].data, par_on | md_on, rows[i].xbit);
      pop_rx(rows[i].data, rows[i].xbit, 1'h0);
    end
    {div, bit_clks, par_on, md_on, tx_on, two_stop} <= {8'h01, 16'h0010, 4'h1};
    write_tx(8'h5C);
    repeat (100) @(posedge clk) #1;
    check("held frames", 8'(nf), 8'(u_peer.frames));
    check("held empty", 1'h0, tx_empty);
    check("held irq", 1'h0, tx_irq);
    tx_on <= 1'h1;
    txd_low();
    repeat (8) @(posedge clk) #1;
    check("empty in start", 1'h0, tx_empty);
    repeat (16) @(posedge clk) #1;
    check("empty after bit", 1'h1, tx_empty);
    check("tx irq empty", 1'h1, tx_irq);
    tx_frame(8'h5C);
    flow_on <= 1'h1;
    u_peer.set_cts(1'h1);
    write_tx(8'h96);
    repeat (100) @(posedge clk) #1;
    check("cts held", 8'(nf), 8'(u_peer.frames));
    u_peer.set_cts(1'h0);
    tx_frame(8'h96);
    write_tx(8'h69);
    txd_low();
    u_peer.set_cts(1'h1);
    tx_frame(8'h69);
    flow_on <= 1'h0;
    write_tx(8'hC3);
    tx_frame(8'hC3);
    u_peer.set_cts(1'h0);
    rx_on <= 1'h0;
    u_peer.send_char(8'h77, 1'h0, 1'h0);
    repeat (20) @(posedge clk) #1;
    check("rx off", 1'h0, rx_ready);
    {rx_on, err_only, par_on} <= 3'h7;
    u_peer.send_char(8'h0F, 1'h1, 1'h0);
    @(posedge clk) #1;
    check("quiet irq", 1'h0, rx_irq);
    pop_rx(8'h0F, 1'h0, 1'h0);
    u_peer.send_char(8'h0F, 1'h1, 1'h1);
    @(posedge clk) #1;
    check("error irq", 1'h1, rx_irq);
    pop_rx(8'h0F, 1'h0, 1'h1);
    {err_only, par_on, md_on} <= 3'h1;
    for (int s = 1; s < 4; s++)
    begin
      scheme <= 2'(s);
      u_peer.send_char(8'h33, 1'h1, 1'h1);
      u_peer.send_char(8'h11, 1'h1, 1'h0);
      u_peer.send_char(8'h5A, 1'h1, 1'h1);
      u_peer.send_char(8'h22, 1'h1, 1'h0);
      check("new frame", 8'(s > 1), rx_nf);
      // Only 8'h22 among the expected bytes is a data byte
      for (int j = 0; j < 2; j++)
        if (md_exp[s - 1][j] != 8'h00)
          pop_rx(md_exp[s - 1][j], md_exp[s - 1][j] != 8'h22, 1'h0);
      repeat (2) @(posedge clk) #1;
      check("md filtered", 1'h0, rx_ready);
    end
    // Zero data with a low bit in the stop slot: framing error and break
    md_on <= 1'h0;
    u_peer.send_char(8'h00, 1'h1, 1'h0);
    @(posedge clk) #1;
    check("rx frame err", 1'h1, rx_ferr);
    check("rx break", 1'h1, rx_brk);
    check("break irq", 1'h1, rx_irq);
    pop_rx(8'h00, 1'h0, 1'h0);
    summarize();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    bad_count++;
    summarize();
  end
endmodule // tb
`default_nettype wire

// ===== uart_baud.sv
// Oversampling tick generator from a 16-bit divisor.
// Assumes divisor is at least 1; a tick is one clock wide.
`timescale 1ns/1ps
`default_nettype none
module uart_baud (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Divisor
  input  wire logic [15:0] divisor,
  // Tick at sixteen times the bit rate
  output logic             tick
);
  logic [15:0] cnt_q;
  wire         wrap = (cnt_q + 16'h0001 >= divisor);

  assign tick = wrap;

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_q <= '0;
    else if (wrap)
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + 16'h0001;
  end
endmodule // uart_baud
`default_nettype wire

// ===== uart_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module uart_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
        rd_q <= rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // uart_fifo
`default_nettype wire

// ===== uart_pkg.sv
// Constants and types shared by the serial transmitter/receiver block.
// Assumes a single 125 MHz system clock and synchronous active-high reset.
// Function
// RULE1: Transmitter starts characters only while tx_on is set.
// RULE2: Receiver accepts characters only while receive enable is set.
// RULE3: With parity on and multidrop off, generate and check even/odd parity.
// RULE4: Holding-empty flag is 1 when data register free, 0 when occupied.
// RULE5: Written byte moves to shift register and is sent automatically.
// RULE6: In multidrop mode ninth bit follows tx_ninth_bit: 1 address, 0 data.
// RULE7: Transmit interrupt is high whenever the transmit data register is empty. The code also requires tx_on, so it stays low while tx_on is clear.
// RULE8: Receive-ready flag is 1 when receive register holds a byte.
// RULE9: Receive interrupt for data, errors, break; status shows the cause.
// RULE10: Setting chooses receive interrupt on data and errors, or errors only.
// RULE11: Multidrop enable turns on ninth bit; two-bit scheme selects matching.
// RULE12: Automatic schemes compare received address bytes to own-address value.
// RULE13: Clear-to-send gates transmission only when flow_ctrl_on is set.
// RULE14: Clear-to-send sampled one clock before each character; holds it off.
// RULE15: Remote deasserts clear-to-send one clock before the character begins.
// RULE16: A character already shifting is finished before pausing.
// RULE17: Bit rate comes from a divisor in high and low byte registers.
// RULE18: Eight data bits lsb first, low start bit, one or two stop bits.
// RULE19: Multidrop ninth bit sent after data, before stop, replacing parity.
// RULE20: Writing transmit data clears the holding-empty flag.
// RULE21: Holding-empty flag sets once the first bit has been shifted out.
// RULE22: Idle transmit line stays high.
// RULE23: Received ninth bit is captured with each character.
`default_nettype none
package uart_pkg;
  localparam int        DATA_W        = 8;
  localparam int        RX_WORD_W     = 12;
  localparam int        FIFO_DEPTH    = 16;
  localparam int        OVS           = 16;
  localparam logic [3:0] OVS_LAST     = 4'hF;
  localparam logic [3:0] OVS_MID      = 4'h7;
  localparam logic [15:0] DIV_RESET   = 16'h0002;
  localparam logic [7:0] ADDR_RESET   = 8'h00;
  localparam logic [1:0] SCHEME_NONE  = 2'h0;
  localparam logic [1:0] SCHEME_ALLADR = 2'h1;
  localparam logic [1:0] SCHEME_MATCH = 2'h2;
  localparam logic [1:0] SCHEME_DATA  = 2'h3;
  localparam int        RXW_NINTH     = 8;
  localparam int        RXW_PERR      = 9;
  localparam int        RXW_FERR      = 10;
  localparam int        RXW_BREAK     = 11;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_EXTRA, ST_STOP} ser_state_e;

  function automatic logic parity_of(input logic [7:0] d, input logic odd);
    parity_of = (^d) ^ odd;
  endfunction
endpackage
`default_nettype wire

// ===== uart_txrx.sv
// Full-duplex serial transmitter/receiver with multidrop and flow control.
// Assumes all control inputs are synchronous to REF_CLK and held steady.
`timescale 1ns/1ps
`default_nettype none
module uart_txrx
  import uart_pkg::*;
(
  // Clock and reset
  input  wire logic                    REF_CLK,
  input  wire logic                    RST,
  // Bit rate divisor bytes
  input  wire logic [7:0]              DIV_HIGH,
  input  wire logic [7:0]              DIV_LOW,
  // Control
  input  wire logic                    TX_ON,
  input  wire logic                    RX_ON,
  input  wire logic                    PARITY_ON,
  input  wire logic                    PARITY_ODD,
  input  wire logic                    TWO_STOP,
  input  wire logic                    FLOW_CTRL_ON,
  input  wire logic                    MULTIDROP_ON,
  input  wire logic [1:0]              MULTIDROP_MATCH_SCHEME,
  input  wire logic                    TX_NINTH_BIT,
  input  wire logic                    RX_ERR_IRQ_ONLY,
  input  wire logic [7:0]              OWN_ADDRESS,
  // Transmit data register write
  input  wire logic                    TX_WRITE,
  input  wire logic [uart_pkg::DATA_W-1:0] TX_DATA,
  // Receive data register read
  input  wire logic                    RX_READ,
  output logic [uart_pkg::DATA_W-1:0]  RX_DATA,
  output logic                         RX_NINTH_BIT,
  output logic                         RX_NEW_FRAME,
  // Status
  output logic                         TX_HOLDING_EMPTY,
  output logic                         RX_BYTE_READY,
  output logic                         RX_PARITY_ERR,
  output logic                         RX_FRAME_ERR,
  output logic                         RX_BREAK,
  output logic                         RX_OVERRUN,
  output logic                         TX_BUSY,
  // Interrupt requests
  output logic                         TX_IRQ,
  output logic                         RX_IRQ,
  // Serial line
  output logic                         TXD,
  input  wire logic                    RXD,
  input  wire logic                    CTS_N
);
  import uart_pkg::*;

  // Shared bit-rate tick
  wire  [15:0] divisor = {DIV_HIGH, DIV_LOW}; // [RULE17]
  logic        tick;
  uart_baud u_baud (
    .clk     (REF_CLK),
    .rst     (RST),
    .divisor (divisor),
    .tick    (tick)
  );

  // ---------------- Transmitter ----------------
  logic [7:0]  hold_q;
  logic        hold_ninth_q;
  logic        hold_full_q;
  ser_state_e  tx_st_q;
  logic [7:0]  tx_sh_q;
  logic        tx_extra_q;
  logic        tx_use_extra_q;
  logic [3:0]  tx_ph_q;
  logic [2:0]  tx_bit_q;
  logic        tx_stop2_q;
  logic        cts_ok_q;
  logic        txd_q;

  wire tx_bit_end = tick && (tx_ph_q == OVS_LAST);
  wire cts_clear  = !FLOW_CTRL_ON || cts_ok_q; // [RULE13]
  wire tx_start   = (tx_st_q == ST_IDLE) && hold_full_q && TX_ON && cts_clear; // [RULE1] [RULE5]
  wire extra_on   = MULTIDROP_ON || PARITY_ON;
  wire extra_val  = MULTIDROP_ON ? hold_ninth_q // [RULE6]
                                 : parity_of(hold_q, PARITY_ODD); // [RULE3]

  assign TX_HOLDING_EMPTY = !hold_full_q; // [RULE4]
  assign TX_IRQ           = TX_ON && !hold_full_q; // [RULE7]
  assign TX_BUSY          = (tx_st_q != ST_IDLE);
  assign TXD              = txd_q;

  // CTS seen one clock before the start decision
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      cts_ok_q <= 1'b0;
    else
      cts_ok_q <= !CTS_N; // [RULE14]
  end

  // Holding register; empties once the start bit has gone out
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      hold_q       <= '0;
      hold_ninth_q <= 1'b0;
      hold_full_q  <= 1'b0;
    end
    else if (TX_WRITE)
    begin
      hold_q       <= TX_DATA;
      hold_ninth_q <= TX_NINTH_BIT;
      hold_full_q  <= 1'b1; // [RULE20]
    end
    else if (tx_st_q == ST_START && tx_bit_end)
      hold_full_q  <= 1'b0; // [RULE21]
  end

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      tx_st_q        <= ST_IDLE;
      tx_sh_q        <= '0;
      tx_extra_q     <= 1'b1;
      tx_use_extra_q <= 1'b0;
      tx_ph_q        <= '0;
      tx_bit_q       <= '0;
      tx_stop2_q     <= 1'b0;
      txd_q          <= 1'b1;
    end
    else
    begin
      if (tick)
        tx_ph_q <= tx_ph_q + 4'h1;
      case (tx_st_q)
        ST_IDLE:
        begin
          txd_q <= 1'b1; // [RULE22]
          if (tx_start)
          begin
            tx_sh_q        <= hold_q;
            tx_extra_q     <= extra_val;
            tx_use_extra_q <= extra_on;
            tx_stop2_q     <= TWO_STOP;
            tx_ph_q        <= '0;
            txd_q          <= 1'b0; // [RULE18]
            tx_st_q        <= ST_START;
          end
        end
        ST_START:
          if (tx_bit_end)
          begin
            txd_q    <= tx_sh_q[0];
            tx_sh_q  <= {1'b1, tx_sh_q[7:1]};
            tx_bit_q <= '0;
            tx_st_q  <= ST_DATA;
          end
        ST_DATA:
          if (tx_bit_end)
          begin
            if (tx_bit_q == 3'h7)
            begin
              txd_q   <= tx_use_extra_q ? tx_extra_q : 1'b1; // [RULE19]
              tx_st_q <= tx_use_extra_q ? ST_EXTRA : ST_STOP;
            end
            else
            begin
              txd_q    <= tx_sh_q[0];
              tx_sh_q  <= {1'b1, tx_sh_q[7:1]};
              tx_bit_q <= tx_bit_q + 3'h1;
            end
          end
        ST_EXTRA:
          if (tx_bit_end)
          begin
            txd_q   <= 1'b1;
            tx_st_q <= ST_STOP;
          end
        ST_STOP:
          if (tx_bit_end)
          begin
            if (tx_stop2_q)
              tx_stop2_q <= 1'b0;
            else
              tx_st_q <= ST_IDLE; // [RULE16]
          end
        default:
          tx_st_q <= ST_IDLE;
      endcase
    end
  end

  // ---------------- Receiver ----------------
  ser_state_e  rx_st_q;
  logic [3:0]  rx_ph_q;
  logic [2:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  logic        rx_extra_q;
  logic        rx_use_extra_q;
  logic        rx_perr_q;
  logic        rx_in_frame_q;
  logic        rx_first_q;

  wire rx_mid    = tick && (rx_ph_q == OVS_MID);
  wire stop_seen = rx_mid && (rx_st_q == ST_STOP);
  wire ferr      = !RXD;
  wire brk       = ferr && (rx_sh_q == 8'h00) && !(rx_use_extra_q && rx_extra_q);
  wire is_addr   = MULTIDROP_ON && rx_extra_q; // [RULE23]
  wire addr_hit  = (rx_sh_q == OWN_ADDRESS); // [RULE12]
  wire auto_sch  = MULTIDROP_MATCH_SCHEME[1];
  wire errs      = ferr || rx_perr_q;

  // Multidrop acceptance for the character just completed
  logic keep;
  always_comb
  begin
    keep = 1'b1;
    if (MULTIDROP_ON) // [RULE11]
    begin
      case (MULTIDROP_MATCH_SCHEME)
        SCHEME_NONE:   keep = 1'b1;
        SCHEME_ALLADR: keep = is_addr;
        SCHEME_MATCH:  keep = is_addr ? addr_hit : rx_in_frame_q;
        SCHEME_DATA:   keep = !is_addr && rx_in_frame_q;
        default:       keep = 1'b1;
      endcase
    end
  end

  wire [RX_WORD_W-1:0] rx_word = {brk, ferr, rx_perr_q, rx_extra_q, rx_sh_q};
  wire                 push    = stop_seen && (keep || errs);
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [RX_WORD_W-1:0] fifo_out;

  // Received characters queue for software
  uart_fifo #(
    .WIDTH (RX_WORD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .clk       (REF_CLK),
    .rst       (RST),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_word),
    .out_valid (fifo_out_valid),
    .out_ready (RX_READ),
    .out_data  (fifo_out)
  );

  assign RX_BYTE_READY = fifo_out_valid; // [RULE8]
  assign RX_DATA       = fifo_out[7:0];
  assign RX_NINTH_BIT  = fifo_out[RXW_NINTH];
  assign RX_PARITY_ERR = fifo_out_valid && fifo_out[RXW_PERR]; // [RULE9]
  assign RX_FRAME_ERR  = fifo_out_valid && fifo_out[RXW_FERR];
  assign RX_BREAK      = fifo_out_valid && fifo_out[RXW_BREAK];
  wire   head_err      = RX_PARITY_ERR || RX_FRAME_ERR || RX_BREAK;
  assign RX_IRQ        = head_err || RX_OVERRUN
                         || (fifo_out_valid && !RX_ERR_IRQ_ONLY); // [RULE10]

  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      rx_st_q        <= ST_IDLE;
      rx_ph_q        <= '0;
      rx_bit_q       <= '0;
      rx_sh_q        <= '0;
      rx_extra_q     <= 1'b0;
      rx_use_extra_q <= 1'b0;
      rx_perr_q      <= 1'b0;
      rx_in_frame_q  <= 1'b0;
      rx_first_q     <= 1'b0;
      RX_OVERRUN     <= 1'b0;
      RX_NEW_FRAME   <= 1'b0;
    end
    else
    begin
      if (tick)
        rx_ph_q <= rx_ph_q + 4'h1;
      if (RX_READ && fifo_out_valid)
        RX_OVERRUN <= 1'b0;
      if (push && !fifo_in_ready)
        RX_OVERRUN <= 1'b1;
      case (rx_st_q)
        ST_IDLE:
          if (RX_ON && !RXD) // [RULE2]
          begin
            rx_ph_q <= '0;
            rx_st_q <= ST_START;
          end
        ST_START:
          if (rx_mid)
          begin
            rx_ph_q        <= OVS_MID + 4'h1;
            rx_bit_q       <= '0;
            rx_use_extra_q <= MULTIDROP_ON || PARITY_ON;
            rx_extra_q     <= 1'b0;
            rx_st_q        <= RXD ? ST_IDLE : ST_DATA;
          end
        ST_DATA:
          if (rx_mid)
          begin
            rx_sh_q  <= {RXD, rx_sh_q[7:1]};
            rx_bit_q <= rx_bit_q + 3'h1;
            if (rx_bit_q == 3'h7)
              rx_st_q <= rx_use_extra_q ? ST_EXTRA : ST_STOP;
          end
        ST_EXTRA:
          if (rx_mid)
          begin
            rx_extra_q <= RXD;
            rx_perr_q  <= !MULTIDROP_ON && (RXD != parity_of(rx_sh_q, PARITY_ODD)); // [RULE3]
            rx_st_q    <= ST_STOP;
          end
        ST_STOP:
          if (rx_mid)
          begin
            rx_perr_q <= 1'b0;
            rx_st_q   <= ST_IDLE;
            if (is_addr && auto_sch)
            begin
              rx_in_frame_q <= addr_hit;
              rx_first_q    <= addr_hit;
            end
            else if (push && !is_addr)
              rx_first_q <= 1'b0;
            if (push && !is_addr)
              RX_NEW_FRAME <= rx_first_q && auto_sch;
          end
        default:
          rx_st_q <= ST_IDLE;
      endcase
    end
  end
endmodule // uart_txrx
`default_nettype wire

// ===== uart_txrx_assertions.sv
// Port-level checks for the serial block.
// Bound into uart_txrx; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module uart_txrx_assertions (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // Controls
  input wire logic TX_ON,
  input wire logic FLOW_CTRL_ON,
  input wire logic CTS_N,
  input wire logic TX_WRITE,
  input wire logic RX_READ,
  input wire logic RX_ERR_IRQ_ONLY,
  // Observed outputs
  input wire logic TXD,
  input wire logic TX_BUSY,
  input wire logic TX_HOLDING_EMPTY,
  input wire logic TX_IRQ,
  input wire logic RX_IRQ,
  input wire logic RX_BYTE_READY,
  input wire logic RX_PARITY_ERR,
  input wire logic RX_FRAME_ERR,
  input wire logic RX_OVERRUN
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  tx_off_idle_a: assert property (!TX_ON && !TX_BUSY |=> TXD)
    else $error("character started while transmit disabled");
  cts_hold_a: assert property (FLOW_CTRL_ON && $past(CTS_N) && !TX_BUSY |=> TXD)
    else $error("character started while clear-to-send deasserted");
  write_clears_a: assert property (TX_WRITE |=> !TX_HOLDING_EMPTY)
    else $error("holding empty still set after a write");
  tx_irq_level_a: assert property (TX_IRQ == (TX_ON && TX_HOLDING_EMPTY))
    else $error("transmit request does not follow holding empty");
  hold_first_bit_a: assert property ($rose(TX_BUSY) |-> !TX_HOLDING_EMPTY [*8])
    else $error("holding empty set before start bit shifted");
  empty_in_char_a: assert property ($rose(TX_HOLDING_EMPTY) |-> TX_BUSY)
    else $error("holding empty set outside a character");
  rx_data_irq_a: assert property (RX_BYTE_READY && !RX_ERR_IRQ_ONLY |-> RX_IRQ)
    else $error("no receive request for a ready byte");
  err_only_quiet_a: assert property (RX_ERR_IRQ_ONLY && !RX_OVERRUN
    && !(RX_BYTE_READY && (RX_PARITY_ERR || RX_FRAME_ERR)) |-> !RX_IRQ)
    else $error("receive request without error in errors-only mode");
  rx_ready_hold_a: assert property (RX_BYTE_READY && !RX_READ |=> RX_BYTE_READY)
    else $error("receive ready dropped without a read");
endmodule // uart_txrx_assertions
bind uart_txrx uart_txrx_assertions u_chk (.REF_CLK(REF_CLK), .RST(RST), .TX_ON(TX_ON),
  .FLOW_CTRL_ON(FLOW_CTRL_ON), .CTS_N(CTS_N), .TX_WRITE(TX_WRITE), .RX_READ(RX_READ),
  .RX_ERR_IRQ_ONLY(RX_ERR_IRQ_ONLY), .TXD(TXD), .TX_BUSY(TX_BUSY), .TX_IRQ(TX_IRQ),
  .TX_HOLDING_EMPTY(TX_HOLDING_EMPTY), .RX_IRQ(RX_IRQ), .RX_BYTE_READY(RX_BYTE_READY),
  .RX_PARITY_ERR(RX_PARITY_ERR), .RX_FRAME_ERR(RX_FRAME_ERR), .RX_OVERRUN(RX_OVERRUN));
`default_nettype wire
